// ==== hdl/pfm_cfg.svh ====
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

// Protection type register field positions.
`define PFM_PT_TRACK_EN      7
`define PFM_PT_PHASE_EN      6
`define PFM_PT_TRACK_LATCH   5
`define PFM_PT_OT_LATCH      4
`define PFM_PT_OC_LATCH      3
`define PFM_PT_UV_LATCH      2
`define PFM_PT_OV_LATCH      1
`define PFM_PT_PV_LATCH      0
`define PFM_PT_RESET         8'h43

// Threshold register fields and reset.
`define PFM_TH_PGLOW_BIT     4
`define PFM_TH_RESET         8'h08

// Propagation register fields and reset.
`define PFM_PR_OTW_REPORT    7
`define PFM_PR_PG_REPORT     6
`define PFM_PR_RESET         8'h3F

// Current limit register reset; temperature compensation bit.
`define PFM_CL_TCE_BIT       4
`define PFM_CL_RESET         8'h1B

// Undervoltage level percentages per code; power-good window limits.
`define PFM_UV_PCT_0         8'd75
`define PFM_UV_PCT_1         8'd80
`define PFM_UV_PCT_2         8'd85
`define PFM_PG_HIGH_PCT      8'd110
`define PFM_PG_LOW_PCT_0     8'd90
`define PFM_PG_LOW_PCT_1     8'd95

// Temperature thresholds in degrees C.
`define PFM_OTW_SET_C        8'd120
`define PFM_OTW_CLR_C        8'd117

// Retry interval.
`define PFM_RETRY_MS         130
`define PFM_CLK_MHZ          200
`define PFM_RETRY_CYCLES     (`PFM_RETRY_MS * 1000 * `PFM_CLK_MHZ)

// Status register bit positions (flags active low).
`define PFM_ST_OTW           7
`define PFM_ST_PG            6
`define PFM_ST_TRACK         5
`define PFM_ST_OT            4
`define PFM_ST_OC            3
`define PFM_ST_UV            2
`define PFM_ST_OV            1
`define PFM_ST_PV            0

`endif

// ==== hdl/pfm_pkg.sv ====
package pfm_pkg;
  // Power stage state; Gray codes along off, ramp, steady, ramp down.
  typedef enum logic [1:0] {
    PFM_OFF    = 2'b00,
    PFM_RAMP   = 2'b01,
    PFM_STEADY = 2'b11,
    PFM_FALL   = 2'b10
  } pfm_state_t;
endpackage

// ==== hdl/pfm_retry_timer.sv ====
`timescale 1ns/100ps
`include "pfm_cfg.svh"

// Down counter that measures the retry interval after a trip.
module pfm_retry_timer #(
  parameter int unsigned RETRY_CYCLES = `PFM_RETRY_CYCLES
) (
  input  wire logic core_clk,  // Device clock.
  input  wire logic sys_rst,   // Synchronous reset, active high.
  input  wire logic reload,    // Restart the interval.
  output logic      expired    // Interval has run out.
);
  logic [27:0] count_q;
  logic [27:0] count_d;

  // Reload wins over counting so a new trip always restarts the full wait.
  assign count_d = reload ? 28'(RETRY_CYCLES - 1) :
                   (count_q != 28'h0000000) ? count_q - 28'h0000001 : count_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= 28'h0000000;
      expired <= 1'b1;
    end else begin
      count_q <= count_d;
      expired <= !reload && (count_q == 28'h0000000);
    end
  end
endmodule

// ==== hdl/pol_protection_fault_manager.sv ====
`timescale 1ns/100ps
`include "pfm_cfg.svh"

// Function
// - Thresholds scale with active setpoint
// - Software selects latching and disables protections
// - Non-latching retries every 130 ms
// - Latching stays off until release
// - Warnings never shut converter down
// - Above 120 C raise temperature warning
// - Temperature report needs its enable
// - Temperature warning clears below 117 C
// - Power-good low outside voltage window
// - Power-good held low during transitions
// - Power-good warning sets flag, reports
// - Back in window releases power-good
// - External low pin means warning
// - Any fault turns converter off
// - Overcurrent armed above pre-bias only
// - Current limit plus undervoltage fast-off
// - Undervoltage armed only in steady state
// - Undervoltage without overcurrent ramps down
// - Status flags are active low
// - Undervoltage code picks 75/80/85 percent
module pol_protection_fault_manager
  import pfm_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = `PFM_RETRY_CYCLES
) (
  input  wire logic        core_clk,        // Device clock, 200 MHz.
  input  wire logic        sys_rst,         // Synchronous reset, active high.
  input  wire logic        cfgWrite,        // One-cycle register write strobe.
  input  wire logic [1:0]  cfgSel,          // 0 type, 1 threshold, 2 propagation, 3 limit.
  input  wire logic [7:0]  cfgWdata,        // Register write data.
  input  wire logic        statusClear,     // Clear released latched flags.
  input  wire logic        turnOnCmd,       // Turn-on command level.
  input  wire logic [7:0]  vOutPct,         // Output voltage as percent of setpoint.
  input  wire logic [7:0]  vPreBiasPct,     // Pre-bias voltage, percent of setpoint.
  input  wire logic [7:0]  tempC,           // Controller temperature, degrees C.
  input  wire logic        currentLimit,    // Output current at limit.
  input  wire logic        overTempHit,     // Controller above fault temperature.
  input  wire logic        trackErr,        // Tracking deviation too large.
  input  wire logic        overVoltHit,     // Output above overvoltage level.
  input  wire logic        phaseVoltHit,    // Phase voltage error seen.
  input  wire logic        rampDone,        // Output ramp has reached target.
  input  wire logic        levelChange,     // Setpoint transition in progress.
  input  wire logic        powerGoodPinIn,  // Sensed level of power-good wire.
  output logic             powerGoodPinOe,  // Pull power-good wire low when high.
  output logic             powerGoodPinOut, // Driven value, always low.
  output logic             convEnable,      // Converter switching allowed.
  output logic             fastOff,         // Both switches off now.
  output logic             rampDown,        // Regular ramped turn-off.
  output logic             otwReport,       // Temperature warning to manager.
  output logic             pgReport,        // Power-good warning to manager.
  output logic [7:0]       protectionStatus, // Active-low flags.
  output logic [7:0]       typeReadback,    // Protection type register.
  output logic [7:0]       thresholdReadback, // Threshold register.
  output logic [7:0]       propagationReadback, // Propagation register.
  output logic [7:0]       limitReadback    // Current limit register.
);

  // Percent-of-setpoint threshold from the undervoltage code.
  function automatic logic [7:0] uvPct(input logic [1:0] code);
    unique case (code)
      2'b00:   uvPct = `PFM_UV_PCT_0;
      2'b01:   uvPct = `PFM_UV_PCT_1;
      default: uvPct = `PFM_UV_PCT_2;
    endcase
  endfunction

  logic [7:0] protTypeQ;
  logic [7:0] threshQ;
  logic [7:0] propQ;
  logic [7:0] limitQ;
  pfm_state_t state_q;
  pfm_state_t state_d;
  logic [7:0] faultLat_q;
  logic [7:0] faultLat_d;
  logic       otw_q;
  logic       turnOnPrev_q;
  logic       retryExpired;

  // Registers; the software-visible configuration steers the thresholds, enables, latching and reports.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      protTypeQ <= `PFM_PT_RESET;
      threshQ   <= `PFM_TH_RESET;
      propQ     <= `PFM_PR_RESET;
      limitQ    <= `PFM_CL_RESET;
    end else if (cfgWrite) begin
      unique case (cfgSel)
        2'd0: protTypeQ <= cfgWdata;
        2'd1: threshQ   <= {3'b000, cfgWdata[4:0]};
        2'd2: propQ     <= cfgWdata;
        2'd3: limitQ    <= cfgWdata;
      endcase
    end
  end

  // Thresholds are compared in percent of setpoint, so they follow margining.
  wire [7:0] uvThresh   = uvPct(threshQ[1:0]);
  wire [7:0] pgLowPct   = threshQ[`PFM_TH_PGLOW_BIT] ? `PFM_PG_LOW_PCT_1 : `PFM_PG_LOW_PCT_0;
  wire       belowUv    = vOutPct < uvThresh;
  wire       outOfWin   = (vOutPct > `PFM_PG_HIGH_PCT) || (vOutPct < pgLowPct);
  wire       steady     = (state_q == PFM_STEADY) && rampDone && !levelChange;
  wire       aboveBias  = vOutPct > vPreBiasPct;

  // Protection detection with arming conditions.
  wire ocHit  = aboveBias && currentLimit && belowUv;
  wire uvHit  = steady && belowUv && !ocHit;
  wire trHit  = protTypeQ[`PFM_PT_TRACK_EN] && (state_q == PFM_RAMP) && trackErr;
  wire pvHit  = protTypeQ[`PFM_PT_PHASE_EN] && phaseVoltHit;
  wire ovHit  = aboveBias && overVoltHit;
  wire [7:0] hitVec = {2'b00, trHit, overTempHit, ocHit, uvHit, ovHit, pvHit};
  wire       anyHit = |hitVec;

  // Non-latching causes release themselves; latching ones wait for a clear.
  wire [7:0] latchSel = {2'b00, protTypeQ[5:0]};
  wire       turnOnRecycle = turnOnCmd && !turnOnPrev_q;
  wire       causeGone     = !anyHit;
  wire       releaseLat    = statusClear || turnOnRecycle;
  always_comb begin
    faultLat_d = faultLat_q | hitVec;
    if (causeGone) begin
      faultLat_d = faultLat_q & latchSel;
      if (releaseLat) begin
        faultLat_d = 8'h00;
      end
    end
  end

  wire tripNow    = anyHit && (state_q != PFM_OFF);
  wire restartOk  = retryExpired && causeGone && (faultLat_q == 8'h00) && turnOnCmd;

  // Power stage sequencing; warnings never enter this decision.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PFM_OFF:    if (restartOk) state_d = PFM_RAMP;
      PFM_RAMP:   if (tripNow) state_d = PFM_FALL;
                  else if (!turnOnCmd) state_d = PFM_FALL;
                  else if (rampDone) state_d = PFM_STEADY;
      PFM_STEADY: if (tripNow || !turnOnCmd) state_d = PFM_FALL;
      PFM_FALL:   state_d = PFM_OFF;
    endcase
  end

  // Overtemperature warning with hysteresis.
  wire otwSet = tempC > `PFM_OTW_SET_C;
  wire otwClr = tempC < `PFM_OTW_CLR_C;
  // The flag and the report use the next value, so they follow the sampled temperature by one edge.
  wire otwNext = otwSet || (otw_q && !otwClr);

  // Power-good warning: outside window, not steady, or someone pulls the wire low.
  wire pgBad  = !steady || outOfWin || !powerGoodPinIn;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q      <= PFM_OFF;
      faultLat_q   <= 8'h00;
      otw_q        <= 1'b0;
      turnOnPrev_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      faultLat_q   <= faultLat_d;
      turnOnPrev_q <= turnOnCmd;
      otw_q        <= otwNext;
    end
  end

  // Retry interval restarts on each trip.
  pfm_retry_timer #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_retry (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .reload   (tripNow),
    .expired  (retryExpired)
  );

  // Registered outputs; flags read 0 while active.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerGoodPinOe      <= 1'b1;
      powerGoodPinOut     <= 1'b0;
      convEnable          <= 1'b0;
      fastOff             <= 1'b0;
      rampDown            <= 1'b0;
      otwReport           <= 1'b0;
      pgReport            <= 1'b0;
      protectionStatus    <= 8'hFF;
      typeReadback        <= `PFM_PT_RESET;
      thresholdReadback   <= `PFM_TH_RESET;
      propagationReadback <= `PFM_PR_RESET;
      limitReadback       <= `PFM_CL_RESET;
    end else begin
      // Only our own window and steady checks drive the wire, so an external pull is not self-held.
      powerGoodPinOe      <= !steady || outOfWin;
      powerGoodPinOut     <= 1'b0;
      convEnable          <= (state_d == PFM_RAMP) || (state_d == PFM_STEADY);
      fastOff             <= tripNow && (ocHit || trHit || ovHit);
      rampDown            <= tripNow && (uvHit || overTempHit);
      otwReport           <= otwNext && propQ[`PFM_PR_OTW_REPORT];
      pgReport            <= pgBad && propQ[`PFM_PR_PG_REPORT];
      protectionStatus    <= ~({otwNext, pgBad, 6'b000000} | faultLat_d);
      typeReadback        <= protTypeQ;
      thresholdReadback   <= threshQ;
      propagationReadback <= propQ;
      limitReadback       <= limitQ;
    end
  end

endmodule

// ==== verification/pfm_chk.sv ====
`timescale 1ns/100ps
// Watches flag timing, the power-good wire and the restart spacing at the block ports.
module pfm_chk #(
  parameter int unsigned RETRY_CYCLES = 20
) (
  input wire logic       core_clk,            // Device clock.
  input wire logic       sys_rst,             // Synchronous reset.
  input wire logic [7:0] tempC,               // Temperature.
  input wire logic [7:0] vOutPct,             // Output voltage.
  input wire logic       levelChange,         // Setpoint move.
  input wire logic       powerGoodPinIn,      // Wire level.
  input wire logic       powerGoodPinOe,      // Wire pull-down.
  input wire logic       convEnable,          // Converter on.
  input wire logic       fastOff,             // Fast turn-off.
  input wire logic       rampDown,            // Ramped turn-off.
  input wire logic       otwReport,           // Warning report.
  input wire logic [7:0] propagationReadback, // Report enables.
  input wire logic [7:0] protectionStatus     // Flags.
);
  int unsigned offCnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Off-time counter; it saturates at reset so the first start is never flagged.
  always_ff @(posedge core_clk) begin
    if (sys_rst) offCnt_q <= RETRY_CYCLES;
    else if (convEnable) offCnt_q <= 0;
    else if (offCnt_q < RETRY_CYCLES) offCnt_q <= offCnt_q + 1;
  end
  chk_otw_set: assert property (tempC > 8'h78 |=> !protectionStatus[7])
    else $error("temperature warning flag not set");
  chk_otw_clear: assert property (tempC < 8'h75 |=> protectionStatus[7])
    else $error("temperature warning flag not cleared");
  chk_otw_report: assert property ((!propagationReadback[7]) [*2] |-> !otwReport)
    else $error("temperature warning reported while disabled");
  chk_pg_window: assert property (vOutPct > 8'h6E |=> powerGoodPinOe)
    else $error("power-good not pulled low above window");
  chk_pg_transition: assert property (levelChange |=> powerGoodPinOe)
    else $error("power-good released during transition");
  chk_pg_external: assert property (!powerGoodPinIn && !powerGoodPinOe |=> !protectionStatus[6])
    else $error("external power-good low not flagged");
  chk_fault_off: assert property (fastOff || rampDown |-> !convEnable)
    else $error("converter still on after a fault");
  chk_retry_gap: assert property ($rose(convEnable) |-> offCnt_q + 1 >= RETRY_CYCLES)
    else $error("restart before the retry interval");
  chk_reset_flags: assert property ($fell(sys_rst) |-> protectionStatus == 8'hFF && !convEnable)
    else $error("flags not inactive after reset");
  cover property ($rose(convEnable));
  cover property (fastOff);
  cover property (rampDown);
endmodule

bind pol_protection_fault_manager pfm_chk #(.RETRY_CYCLES(RETRY_CYCLES)) chk (
  .core_clk, .sys_rst, .tempC, .vOutPct, .levelChange, .powerGoodPinIn, .powerGoodPinOe,
  .convEnable, .fastOff, .rampDown, .otwReport, .propagationReadback, .protectionStatus
);

// ==== verification/pfm_power_manager.sv ====
`timescale 1ns/100ps
// Manager side: reads the status word every fourth cycle without pause.
module pfm_power_manager (
  input  wire logic       core_clk,         // Device clock.
  input  wire logic       sys_rst,          // Synchronous reset.
  input  wire logic [7:0] protectionStatus, // Flags from the device.
  output logic [7:0]      polledStatus      // Last word read.
);
  logic [1:0] pollCnt_q;
  // A warning shorter than the poll period could be missed, so the period is kept short.
  always_ff @(posedge core_clk) begin
    pollCnt_q <= sys_rst ? 2'h0 : pollCnt_q + 2'h1;
    if (sys_rst) polledStatus <= 8'hFF;
    else if (pollCnt_q == 2'h0) polledStatus <= protectionStatus;
  end
endmodule

// ==== verification/pol_protection_fault_manager_tb.sv ====
`timescale 1ns/100ps
module pol_protection_fault_manager_tb;
  logic       core_clk = 0, sys_rst = 1, cfgWrite = 0, statusClear = 0, turnOnCmd = 0;
  logic       currentLimit = 0, rampDone = 1, levelChange = 0, extPull = 0, overVoltHit = 0;
  logic [1:0] cfgSel = 0;
  logic [7:0] cfgWdata = 0, vOutPct = 8'h64, tempC = 8'h19;
  logic       powerGoodPinOe, powerGoodPinOut, convEnable, fastOff, rampDown, otwReport, pgReport;
  logic [7:0] protectionStatus, typeReadback, thresholdReadback, propagationReadback;
  logic [7:0] limitReadback, polledStatus;
  int         num_errors = 0, tests_run = 0;
  // The wire is low whenever the device or the outside circuit pulls it.
  wire        powerGoodPinIn = ~(powerGoodPinOe | extPull);
  pol_protection_fault_manager #(.RETRY_CYCLES(20)) dut (.core_clk, .sys_rst, .cfgWrite,
    .cfgSel, .cfgWdata, .statusClear, .turnOnCmd, .vOutPct, .vPreBiasPct(8'h00), .tempC,
    .currentLimit, .overTempHit(1'b0), .trackErr(1'b0), .overVoltHit,
    .phaseVoltHit(1'b0), .rampDone, .levelChange, .powerGoodPinIn, .powerGoodPinOe,
    .powerGoodPinOut, .convEnable, .fastOff, .rampDown, .otwReport, .pgReport,
    .protectionStatus, .typeReadback, .thresholdReadback, .propagationReadback, .limitReadback);
  pfm_power_manager mgr (.core_clk, .sys_rst, .protectionStatus, .polledStatus);
  // Clock at 200 MHz.
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Readback is settled one edge after the write edge.
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    cfgSel = s;
    cfgWdata = d;
    cfgWrite = 1;
    cyc(1);
    cfgWrite = 0;
    cyc(2);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for the converter enable; running out ends the run.
  task automatic wait_en(input logic v, input int n);
    for (int i = 0; i < n && convEnable !== v; i++) cyc(1);
    chk("convEnable wait", convEnable, v);
    if (convEnable !== v) tally_and_finish();
  endtask
  // Main sequence: registers, start-up, warnings, then both fault kinds.
  initial begin
    cyc(8);
    sys_rst = 0;
    cyc(1);
    chk("type", typeReadback, 8'h43);
    chk("threshold", thresholdReadback, 8'h08);
    chk("propagation", propagationReadback, 8'h3F);
    chk("limit", limitReadback, 8'h1B);
    chk("status", protectionStatus, 8'hBF);
    chk("pgOut", powerGoodPinOut, 0);
    wr(2'h1, 8'hFF);
    chk("threshold", thresholdReadback, 8'h1F);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h00);
    chk("type", typeReadback, 8'h00);
    $display("test registers done");
    turnOnCmd = 1;
    wait_en(1, 10);
    cyc(4);
    chk("pgOe", powerGoodPinOe, 0);
    levelChange = 1;
    cyc(2);
    chk("pgOe", powerGoodPinOe, 1);
    levelChange = 0;
    cyc(4);
    chk("pgOe", powerGoodPinOe, 0);
    $display("test startup done");
    tempC = 8'h79; // Above 120 degrees.
    cyc(2);
    chk("otwFlag", protectionStatus[7], 0);
    chk("convEnable", convEnable, 1);
    chk("otwReport", otwReport, 0);
    wr(2'h2, 8'hFF);
    chk("otwReport", otwReport, 1);
    tempC = 8'h76; // Inside the hysteresis band.
    cyc(6);
    chk("otwFlag", protectionStatus[7], 0);
    chk("polled", polledStatus[7], 0);
    tempC = 8'h74;
    cyc(2);
    chk("otwFlag", protectionStatus[7], 1);
    $display("test temperature done");
    vOutPct = 8'h70; // 112 percent.
    cyc(2);
    chk("pgOe", powerGoodPinOe, 1);
    chk("pgFlag", protectionStatus[6], 0);
    chk("pgReport", pgReport, 1);
    vOutPct = 8'h5E; // 94 percent, inside the 90 percent window.
    cyc(2);
    chk("pgOe", powerGoodPinOe, 0);
    chk("pgFlag", protectionStatus[6], 1);
    wr(2'h1, 8'h11);
    chk("pgOe", powerGoodPinOe, 1);
    wr(2'h1, 8'h01);
    extPull = 1;
    cyc(2);
    chk("pgFlag", protectionStatus[6], 0);
    chk("pgReport", pgReport, 1);
    extPull = 0;
    vOutPct = 8'h64;
    cyc(2);
    $display("test power good done");
    vOutPct = 8'h4E; // 78 percent, below the 80 percent level but above 75.
    cyc(1);
    chk("uvFlag", protectionStatus[2], 0);
    chk("rampDown", rampDown, 1);
    chk("convEnable", convEnable, 0);
    vOutPct = 8'h64;
    cyc(10);
    chk("convEnable", convEnable, 0);
    wait_en(1, 40);
    cyc(4);
    $display("test undervoltage done");
    wr(2'h0, 8'h08);
    currentLimit = 1;
    vOutPct = 8'h46;
    cyc(2);
    chk("ocFlag", protectionStatus[3], 0);
    chk("fastOff", fastOff, 1);
    currentLimit = 0;
    vOutPct = 8'h64;
    cyc(40);
    chk("convEnable", convEnable, 0);
    statusClear = 1;
    cyc(1);
    statusClear = 0;
    wait_en(1, 10);
    chk("ocFlag", protectionStatus[3], 1);
    $display("test overcurrent done");
    overVoltHit = 1;
    cyc(1);
    chk("fastOff", fastOff, 1);
    chk("ovFlag", protectionStatus[1], 0);
    chk("convEnable", convEnable, 0);
    overVoltHit = 0;
    wait_en(1, 40);
    $display("test overvoltage done");
    tally_and_finish();
  end
endmodule
